/* File: e1o_regs.svh */
`ifndef E1O_REGS_SVH
`define E1O_REGS_SVH

// ********************************************************************
// register indexes (byte address is four times the index)
// ********************************************************************
`define E1O_IDX_CRC_CTRL 14'h010B
`define E1O_IDX_SIG_CHG_TS8 14'h010E
`define E1O_IDX_SIG_CHG_TS16 14'h010F
`define E1O_IDX_SIG_CHG_TS24 14'h0110
`define E1O_IDX_NATIONAL 14'h0111
`define E1O_IDX_EXTRA 14'h0112
`define E1O_IDX_LOSS_STAT 14'h0120

// ********************************************************************
// field positions
// ********************************************************************
`define E1O_CRIT_LSB 0
`define E1O_EXTRA_INFRAME_BIT 7
`define E1O_EXTRA_COMPLY_BIT 6
`define E1O_EXTRA_FIRST_BIT 3
`define E1O_EXTRA_YELLOW_BIT 2
`define E1O_EXTRA_SECOND_BIT 1
`define E1O_EXTRA_THIRD_BIT 0
`define E1O_NAT_SI_ALIGN_BIT 7
`define E1O_NAT_SI_OTHER_BIT 6
`define E1O_NAT_RAI_BIT 5
`define E1O_LOSS_STAT_BIT 0

// ********************************************************************
// reset values
// ********************************************************************
`define E1O_SIG_CHG_RST 8'h00
`define E1O_NAT_RST 8'h00
`define E1O_TS16_RST 4'h0
`define E1O_CRIT_RST 2'h0
`define E1O_COMPLY_RST 1'b0

// ********************************************************************
// counts and times
// ********************************************************************
`define E1O_CONSEC_CODE0 4'h4
`define E1O_CONSEC_CODE1 4'h2
`define E1O_CONSEC_CODE2 4'h8
`define E1O_CONSEC_COMPLY 4'h4
`define E1O_ERR_LIMIT 915
`define E1O_WINDOW_NS 1000000000
`define E1O_FRAME_NS 125000
`define E1O_FIRST_TS 8

`endif

/* File: e1o_pkg.sv */
// ********************************************************************
// shared types
// ********************************************************************
package e1o_pkg;

  // timeslot 0 octet of one received frame
  typedef struct packed {
    logic valid;
    logic is_fas;
    logic [7:0] data;
  } e1o_ts0_t;

  // timeslot 16 octet of frame 0 of the signalling multiframe
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } e1o_ts16_t;

  // one received signalling nibble
  typedef struct packed {
    logic valid;
    logic [4:0] ts;
    logic [3:0] abcd;
  } e1o_cas_t;

  // crc-4 events from the framer
  typedef struct packed {
    logic frame_tick;
    logic crc_err;
    logic mf_check;
    logic mf_bad;
  } e1o_crc_ev_t;

  typedef enum logic [1:0] {
    E1O_RESP_OKAY = 2'h0,
    E1O_RESP_SLVERR = 2'h2
  } e1o_resp_t;

endpackage

/* File: e1o_rx_overhead_status.sv */
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "e1o_regs.svh"
// How it works
// - change flags ts8..15, bit7 is ts8
// - change flags ts16..23, bit7 is ts16
// - change flags ts24..31, bit7 is ts24
// - flag set on change, read clears
// - flags only set in cas mode, held cleared without cas
// - latch si of fas frames, bit 7
// - latch si of other frames, bit 6
// - latch remote alarm bit into bit 5
// - latch sa4..sa8 into bits 4..0
// - bit 7 of extra shows in-frame
// - code 11 standard: 915 errors per second
// - code 11 compliant: 4 bad or 915
// - ts16 bit 5 into extra bit 3
// - ts16 bit 6 yellow alarm, bit 2
// - ts16 bit 7 into extra bit 1
// - ts16 bit 8 into extra bit 0
// - ts16 bits only latched in cas mode
// - codes 00/01/10 pick 4/2/8 bad
module e1o_rx_overhead_status import e1o_pkg::*; #(
  parameter int ADDR_W = 16,
  parameter int WINDOW_FRAMES = `E1O_WINDOW_NS / `E1O_FRAME_NS,
  parameter int ERR_LIMIT = `E1O_ERR_LIMIT
) (
  input wire logic aclk,              // framer clock
  input wire logic aresetn,           // sync reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid,           // write address valid
  output logic awready,               // write address taken
  input wire logic [31:0] wdata,      // write data
  input wire logic [3:0] wstrb,       // byte enables
  input wire logic wvalid,            // write data valid
  output logic wready,                // write data taken
  output logic [1:0] bresp,           // write response
  output logic bvalid,                // write response valid
  input wire logic bready,            // write response taken
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid,           // read address valid
  output logic arready,               // read address taken
  output logic [31:0] rdata,          // read data
  output logic [1:0] rresp,           // read response
  output logic rvalid,                // read data valid
  input wire logic rready,            // read data taken
  input wire e1o_ts0_t ts0_in,        // timeslot 0 octet
  input wire e1o_ts16_t ts16_in,      // timeslot 16, frame 0
  input wire e1o_cas_t cas_in,        // signalling nibble
  input wire e1o_crc_ev_t crc_in,     // crc-4 events
  input wire logic cas_mode,          // stream carries cas
  input wire logic in_frame,          // framer declares in-frame
  output logic crc_loss_event         // loss of crc-4 mf declared
);

  // ******************************************************************
  // state
  // ******************************************************************
  logic [3:0] last_abcd [32];
  logic [31:8] chg_flags;
  logic [7:0] nat_bits;
  logic [3:0] ts16_bits;
  logic [1:0] crc_loss_criterion;
  logic crc_loss_compliance_sel;
  logic loss_sticky;
  logic [3:0] mfa_run;
  logic [13:0] frame_cnt;
  logic [9:0] err_cnt;
  logic win_declared;

  // ******************************************************************
  // bus decode
  // ******************************************************************
  wire aw_go = awvalid && wvalid && !awready && !bvalid;
  wire wr_take = awvalid && awready && wvalid && wready;
  wire [13:0] wr_idx = 14'(awaddr[ADDR_W-1:2]);
  wire ar_go = arvalid && !arready && !rvalid;
  wire rd_take = arvalid && arready;
  wire [13:0] rd_idx = 14'(araddr[ADDR_W-1:2]);
  wire wr_crc = wr_take && wstrb[0] && wr_idx == `E1O_IDX_CRC_CTRL;
  wire wr_extra = wr_take && wstrb[0] && wr_idx == `E1O_IDX_EXTRA;
  wire rd_ts8 = rd_take && rd_idx == `E1O_IDX_SIG_CHG_TS8;
  wire rd_ts16 = rd_take && rd_idx == `E1O_IDX_SIG_CHG_TS16;
  wire rd_ts24 = rd_take && rd_idx == `E1O_IDX_SIG_CHG_TS24;
  wire rd_loss = rd_take && rd_idx == `E1O_IDX_LOSS_STAT;
  wire wr_mapped = wr_idx == `E1O_IDX_CRC_CTRL || wr_idx == `E1O_IDX_EXTRA ||
                   wr_idx == `E1O_IDX_SIG_CHG_TS8 || wr_idx == `E1O_IDX_SIG_CHG_TS16 ||
                   wr_idx == `E1O_IDX_SIG_CHG_TS24 || wr_idx == `E1O_IDX_NATIONAL ||
                   wr_idx == `E1O_IDX_LOSS_STAT;

  // ******************************************************************
  // signalling change detection
  // ******************************************************************
  // register view: bit 7 is the lowest timeslot of the group
  function automatic logic [7:0] flag_view(input logic [31:8] f, input int base);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8; k++) begin
      r[7-k] = f[base+k];
    end
    return r;
  endfunction

  wire cas_hit = cas_in.valid && cas_mode && cas_in.ts >= 5'(`E1O_FIRST_TS);
  wire change_hit = cas_hit && cas_in.abcd != last_abcd[cas_in.ts];
  logic [31:8] set_vec;
  logic [31:8] clr_vec;
  logic [31:8] next_chg;

  // one-hot set from a changed nibble, clear mask from reads
  always_comb begin
    set_vec = '0;
    if (change_hit) begin
      set_vec[cas_in.ts] = 1'b1;
    end
    clr_vec = {{8{rd_ts24}}, {8{rd_ts16}}, {8{rd_ts8}}};
    next_chg = (chg_flags & ~clr_vec) | set_vec;
    if (!cas_mode) begin
      next_chg = '0;
    end
  end

  // flags, set wins over read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg_flags <= {`E1O_SIG_CHG_RST, `E1O_SIG_CHG_RST, `E1O_SIG_CHG_RST};
    end else begin
      chg_flags <= next_chg;
    end
  end

  // last nibble seen for each of timeslots 8..31, in cas mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 32; i++) begin
        last_abcd[i] <= 4'h0;
      end
    end else if (cas_hit) begin
      last_abcd[cas_in.ts] <= cas_in.abcd;
    end
  end

  // ******************************************************************
  // timeslot 0 and timeslot 16 capture
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nat_bits <= `E1O_NAT_RST;
    end else if (ts0_in.valid && ts0_in.is_fas) begin
      nat_bits[`E1O_NAT_SI_ALIGN_BIT] <= ts0_in.data[7];
    end else if (ts0_in.valid) begin
      nat_bits[`E1O_NAT_SI_OTHER_BIT] <= ts0_in.data[7];
      nat_bits[`E1O_NAT_RAI_BIT] <= ts0_in.data[5];
      nat_bits[4:0] <= ts0_in.data[4:0];
    end
  end

  // extra, yellow and extra bits of frame 0, bits 5..8
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ts16_bits <= `E1O_TS16_RST;
    end else if (ts16_in.valid && cas_mode) begin
      ts16_bits <= ts16_in.data[3:0];
    end
  end

  // ******************************************************************
  // crc-4 multiframe loss criterion
  // ******************************************************************
  logic [3:0] consec_thr;
  always_comb begin
    unique case (crc_loss_criterion)
      2'h0: consec_thr = `E1O_CONSEC_CODE0;
      2'h1: consec_thr = `E1O_CONSEC_CODE1;
      2'h2: consec_thr = `E1O_CONSEC_CODE2;
      2'h3: consec_thr = crc_loss_compliance_sel ? `E1O_CONSEC_COMPLY : 4'h0;
    endcase
  end

  wire bad_mf = crc_in.mf_check && crc_in.mf_bad;
  wire consec_hit = bad_mf && consec_thr != 4'h0 && mfa_run + 4'h1 >= consec_thr;
  // an error on the window's last tick belongs to the next window
  wire win_end = crc_in.frame_tick && frame_cnt == 14'(WINDOW_FRAMES - 1);
  wire count_hit = crc_loss_criterion == 2'h3 && crc_in.crc_err && !win_declared &&
                   !win_end && err_cnt == 10'(ERR_LIMIT - 1);

  // run of errored multiframe alignments, restarted after a declaration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mfa_run <= 4'h0;
    end else if (consec_hit || (crc_in.mf_check && !crc_in.mf_bad)) begin
      mfa_run <= 4'h0;
    end else if (bad_mf && mfa_run != 4'hF) begin
      mfa_run <= mfa_run + 4'h1;
    end
  end

  // one-second window of frames
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_cnt <= 14'h0000;
    end else if (win_end) begin
      frame_cnt <= 14'h0000;
    end else if (crc_in.frame_tick) begin
      frame_cnt <= frame_cnt + 14'h0001;
    end
  end

  // errors in the window; a new window starts from the error seen now
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_cnt <= 10'h000;
      win_declared <= 1'b0;
    end else if (win_end) begin
      err_cnt <= {9'h000, crc_in.crc_err};
      win_declared <= 1'b0;
    end else begin
      if (crc_in.crc_err && err_cnt != 10'(ERR_LIMIT)) begin
        err_cnt <= err_cnt + 10'h001;
      end
      if (count_hit) begin
        win_declared <= 1'b1;
      end
    end
  end

  // declaration pulse and sticky status, set wins over read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_loss_event <= 1'b0;
      loss_sticky <= 1'b0;
    end else begin
      crc_loss_event <= consec_hit || count_hit;
      loss_sticky <= consec_hit || count_hit || (loss_sticky && !rd_loss);
    end
  end

  // ******************************************************************
  // writable controls
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_loss_criterion <= `E1O_CRIT_RST;
      crc_loss_compliance_sel <= `E1O_COMPLY_RST;
    end else begin
      if (wr_crc) begin
        crc_loss_criterion <= wdata[`E1O_CRIT_LSB +: 2];
      end
      if (wr_extra) begin
        crc_loss_compliance_sel <= wdata[`E1O_EXTRA_COMPLY_BIT];
      end
    end
  end

  // ******************************************************************
  // read mux
  // ******************************************************************
  wire [7:0] extra_view = {in_frame, crc_loss_compliance_sel, 2'b00, ts16_bits};
  logic [7:0] rd_byte;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (rd_idx)
      `E1O_IDX_CRC_CTRL: rd_byte = {6'h00, crc_loss_criterion};
      `E1O_IDX_SIG_CHG_TS8: rd_byte = flag_view(chg_flags, 8);
      `E1O_IDX_SIG_CHG_TS16: rd_byte = flag_view(chg_flags, 16);
      `E1O_IDX_SIG_CHG_TS24: rd_byte = flag_view(chg_flags, 24);
      `E1O_IDX_NATIONAL: rd_byte = nat_bits;
      `E1O_IDX_EXTRA: rd_byte = extra_view;
      `E1O_IDX_LOSS_STAT: rd_byte = {7'h00, loss_sticky};
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // ******************************************************************
  // axi4-lite write channel
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= E1O_RESP_OKAY;
    end else begin
      awready <= aw_go;
      wready <= aw_go;
      if (wr_take) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? E1O_RESP_OKAY : E1O_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // axi4-lite read channel
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= E1O_RESP_OKAY;
    end else begin
      arready <= ar_go;
      if (rd_take) begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_byte};
        rresp <= rd_ok ? E1O_RESP_OKAY : E1O_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_read_ts8;
    rd_take && rd_idx == `E1O_IDX_SIG_CHG_TS8;
  endsequence

  sequence s_quiet_cas;
    !cas_in.valid;
  endsequence

  chk_sig_change_set: assert property (
    change_hit && cas_in.ts == 5'd8 |=> chg_flags[8] ##0 rdata[7] || !rvalid)
    else $error("changed timeslot 8 did not raise its flag");

  chk_sig_read_clear: assert property (
    s_read_ts8 ##0 s_quiet_cas |=> chg_flags[15:8] == 8'h00
      ##0 rdata[7:0] == $past(flag_view(chg_flags, 8)))
    else $error("read of ts8 flags did not return and clear them");

  chk_sig_cas_off: assert property (
    !cas_mode |=> chg_flags == '0)
    else $error("change flags active without cas");

  chk_nat_fas_si: assert property (
    ts0_in.valid && ts0_in.is_fas |=> nat_bits[7] == $past(ts0_in.data[7])
      ##0 nat_bits[6:0] == $past(nat_bits[6:0]))
    else $error("fas si bit not latched alone");

  chk_nat_other: assert property (
    ts0_in.valid && !ts0_in.is_fas |=>
      nat_bits[6:0] == {$past(ts0_in.data[7]), $past(ts0_in.data[5]), $past(ts0_in.data[4:0])})
    else $error("non-fas bits not latched");

  chk_inframe_read: assert property (
    rd_take && rd_idx == `E1O_IDX_EXTRA |=> rvalid && rdata[7] == $past(in_frame))
    else $error("in-frame bit does not follow framer");

  chk_ts16_latch: assert property (
    ts16_in.valid |=> ts16_bits == ($past(cas_mode) ? $past(ts16_in.data[3:0])
                                                     : $past(ts16_bits)))
    else $error("timeslot 16 extra bits wrong");

  chk_consec_two: assert property (
    crc_loss_criterion == 2'h1 && bad_mf && mfa_run == 4'h1 |=> crc_loss_event)
    else $error("two bad alignments did not declare loss");

  chk_std_no_consec: assert property (
    crc_loss_criterion == 2'h3 && !crc_loss_compliance_sel && !count_hit |=> !crc_loss_event)
    else $error("standard criterion declared without error count");

  chk_err_count: assert property (
    count_hit |=> crc_loss_event && win_declared)
    else $error("915th error in window not declared");

  chk_window_wrap: assert property (
    win_end && !crc_in.crc_err |=> err_cnt == 10'h000 && frame_cnt == 14'h0000)
    else $error("window did not restart");

  chk_read_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed before taken");

endmodule
`default_nettype wire

/* File: e1o_line_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// far side: receive framer feeding the status block
// ********
module e1o_line_model import e1o_pkg::*; (
  input wire logic aclk,         // framer clock
  output var e1o_ts0_t ts0_in,   // timeslot 0 octet
  output var e1o_ts16_t ts16_in, // timeslot 16 octet
  output var e1o_cas_t cas_in,   // signalling nibble
  output var e1o_crc_ev_t crc_in, // crc-4 events
  output var logic cas_mode,     // stream carries cas
  output var logic in_frame      // framer in-frame
);
  // lines start quiet
  initial begin
    ts0_in = '0;
    ts16_in = '0;
    cas_in = '0;
    crc_in = '0;
    cas_mode = 1'b0;
    in_frame = 1'b0;
  end

  // idle lines show the inverse of the last octet, never a stale copy
  task automatic send_ts0(input logic fas, input logic [7:0] d);
    @(posedge aclk);
    ts0_in <= {1'b1, fas, d};
    @(posedge aclk);
    ts0_in <= {1'b0, ~fas, ~d};
  endtask

  task automatic send_ts16(input logic [7:0] d);
    @(posedge aclk);
    ts16_in <= {1'b1, d};
    @(posedge aclk);
    ts16_in <= {1'b0, ~d};
  endtask

  task automatic send_cas(input logic [4:0] ts, input logic [3:0] abcd);
    @(posedge aclk);
    cas_in <= {1'b1, ts, abcd};
    @(posedge aclk);
    cas_in <= {1'b0, ~ts, ~abcd};
  endtask

  // one-cycle crc event pulse
  task automatic send_crc(input e1o_crc_ev_t e);
    @(posedge aclk);
    crc_in <= e;
    @(posedge aclk);
    crc_in <= '0;
  endtask

  task automatic set_mode(input logic cm, input logic inf);
    @(posedge aclk);
    cas_mode <= cm;
    in_frame <= inf;
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "e1o_regs.svh"
module testbench import e1o_pkg::*; ;
  localparam int WF = 16;
  localparam int EL = 5;
  localparam logic [3:0] TICK = 4'h8;
  localparam logic [3:0] ERR = 4'h4;
  localparam logic [3:0] GOOD = 4'h2;
  localparam logic [3:0] BAD = 4'h3;
  localparam logic [1:0] OK = E1O_RESP_OKAY;
  localparam logic [1:0] SE = E1O_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, crc_loss_event;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  e1o_ts0_t ts0;
  e1o_ts16_t ts16;
  e1o_cas_t cas;
  e1o_crc_ev_t crc;
  logic cas_mode, in_frame;
  int error_cnt = 0;
  int compares = 0;
  int loss_cnt = 0;

  // ********
  // clock, instances, loss pulse counter
  // ********
  always #5 aclk = ~aclk;

  e1o_rx_overhead_status #(.WINDOW_FRAMES(WF), .ERR_LIMIT(EL)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ts0_in(ts0), .ts16_in(ts16), .cas_in(cas), .crc_in(crc), .cas_mode(cas_mode),
    .in_frame(in_frame), .crc_loss_event(crc_loss_event));

  e1o_line_model line (
    .aclk(aclk), .ts0_in(ts0), .ts16_in(ts16), .cas_in(cas), .crc_in(crc),
    .cas_mode(cas_mode), .in_frame(in_frame));

  always @(posedge aclk) begin
    if (crc_loss_event === 1'b1) loss_cnt <= loss_cnt + 1;
  end

  // ********
  // compare, report and bus tasks
  // ********
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: response %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    error_cnt++;
    $display("Error at %0t: handshake %0h expected %0h", $time, 0, 1);
    close_out();
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [3:0] s,
      input logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        chk_resp(bresp, r);
        return;
      end
    end
    timed_out();
  endtask

  task automatic rd(input logic [13:0] idx, input logic [7:0] e, input logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        chk_val(rdata, {24'h000000, e});
        chk_resp(rresp, r);
        return;
      end
    end
    timed_out();
  endtask

  task automatic ev(input int n, input logic [3:0] c);
    repeat (n) line.send_crc(c);
  endtask

  task automatic chk_loss(input int n);
    repeat (2) @(posedge aclk);
    chk_val(32'(loss_cnt), 32'(n));
  endtask

  // ********
  // scenarios
  // ********
  task automatic reset_values();
    rd(`E1O_IDX_SIG_CHG_TS8, 8'h00, OK);
    rd(`E1O_IDX_SIG_CHG_TS16, 8'h00, OK);
    rd(`E1O_IDX_SIG_CHG_TS24, 8'h00, OK);
    rd(`E1O_IDX_EXTRA, 8'h00, OK);
    rd(`E1O_IDX_CRC_CTRL, 8'h00, OK);
    rd(14'h0100, 8'h00, SE);
    wr(14'h0100, 8'hFF, 4'hF, SE);
    wr(`E1O_IDX_NATIONAL, 8'hFF, 4'hF, OK);
    rd(`E1O_IDX_NATIONAL, 8'h00, OK);
  endtask

  task automatic cas_flags();
    int t;
    line.set_mode(1'b1, 1'b1);
    line.send_cas(5'd3, 4'hF);
    for (t = 8; t < 32; t++) begin
      line.send_cas(5'(t), (t == 9) ? 4'h0 : 4'hA);
    end
    rd(`E1O_IDX_SIG_CHG_TS8, 8'hBF, OK);
    rd(`E1O_IDX_SIG_CHG_TS16, 8'hFF, OK);
    rd(`E1O_IDX_SIG_CHG_TS24, 8'hFF, OK);
    rd(`E1O_IDX_SIG_CHG_TS8, 8'h00, OK);
    line.send_cas(5'd8, 4'hA);
    line.send_cas(5'd31, 4'h5);
    rd(`E1O_IDX_SIG_CHG_TS8, 8'h00, OK);
    rd(`E1O_IDX_SIG_CHG_TS24, 8'h01, OK);
    line.send_cas(5'd16, 4'h3);
    line.set_mode(1'b0, 1'b1);
    line.send_cas(5'd23, 4'h1);
    rd(`E1O_IDX_SIG_CHG_TS16, 8'h00, OK);
  endtask

  task automatic national();
    line.send_ts0(1'b1, 8'h80);
    line.send_ts0(1'b0, 8'hBF);
    rd(`E1O_IDX_NATIONAL, 8'hFF, OK);
    line.send_ts0(1'b1, 8'h00);
    rd(`E1O_IDX_NATIONAL, 8'h7F, OK);
    line.send_ts0(1'b0, 8'h45);
    rd(`E1O_IDX_NATIONAL, 8'h05, OK);
  endtask

  task automatic extra();
    line.set_mode(1'b1, 1'b1);
    line.send_ts16(8'h0A);
    rd(`E1O_IDX_EXTRA, 8'h8A, OK);
    wr(`E1O_IDX_EXTRA, 8'hFF, 4'hF, OK);
    wr(`E1O_IDX_EXTRA, 8'h00, 4'h0, OK);
    rd(`E1O_IDX_EXTRA, 8'hCA, OK);
    line.set_mode(1'b1, 1'b0);
    line.send_ts16(8'h05);
    rd(`E1O_IDX_EXTRA, 8'h45, OK);
    line.set_mode(1'b0, 1'b0);
    line.send_ts16(8'h0A);
    rd(`E1O_IDX_EXTRA, 8'h45, OK);
    wr(`E1O_IDX_EXTRA, 8'h00, 4'hF, OK);
  endtask

  task automatic crc_loss();
    wr(`E1O_IDX_CRC_CTRL, 8'h00, 4'hF, OK);
    ev(1, GOOD);
    ev(3, BAD);
    ev(1, GOOD);
    ev(3, BAD);
    chk_loss(0);
    ev(1, BAD);
    chk_loss(1);
    rd(`E1O_IDX_LOSS_STAT, 8'h01, OK);
    rd(`E1O_IDX_LOSS_STAT, 8'h00, OK);
    wr(`E1O_IDX_CRC_CTRL, 8'h01, 4'hF, OK);
    ev(1, GOOD);
    ev(1, BAD);
    chk_loss(1);
    ev(1, BAD);
    chk_loss(2);
    wr(`E1O_IDX_CRC_CTRL, 8'h02, 4'hF, OK);
    ev(1, GOOD);
    ev(7, BAD);
    chk_loss(2);
    ev(1, BAD);
    chk_loss(3);
    wr(`E1O_IDX_CRC_CTRL, 8'h03, 4'hF, OK);
    rd(`E1O_IDX_CRC_CTRL, 8'h03, OK);
    ev(1, GOOD);
    ev(8, BAD);
    chk_loss(3);
    ev(WF, TICK);
    ev(EL - 1, ERR);
    ev(WF, TICK);
    ev(EL - 1, ERR);
    chk_loss(3);
    ev(1, ERR);
    chk_loss(4);
    ev(2, ERR);
    chk_loss(4);
    wr(`E1O_IDX_EXTRA, 8'h40, 4'hF, OK);
    ev(WF, TICK);
    ev(1, GOOD);
    ev(4, BAD);
    chk_loss(5);
    ev(EL, ERR);
    chk_loss(6);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_values();
    cas_flags();
    national();
    extra();
    crc_loss();
    close_out();
  end
endmodule
`default_nettype wire
